// *** verilog/gpt_params.svh ***
// register map, field positions, codes and reset values of the timer
`ifndef GPT_PARAMS_SVH
`define GPT_PARAMS_SVH
// register byte offsets
`define GPT_OFS_CFG 12'h000
`define GPT_OFS_AMODE 12'h004
`define GPT_OFS_BMODE 12'h008
`define GPT_OFS_CTL 12'h00c
`define GPT_OFS_IMR 12'h018
`define GPT_OFS_RIS 12'h01c
`define GPT_OFS_MIS 12'h020
`define GPT_OFS_ICR 12'h024
`define GPT_OFS_AILR 12'h028
`define GPT_OFS_BILR 12'h02c
`define GPT_OFS_AMATCH 12'h030
`define GPT_OFS_BMATCH 12'h034
`define GPT_OFS_APR 12'h038
`define GPT_OFS_BPR 12'h03c
`define GPT_OFS_ACNT 12'h048
`define GPT_OFS_BCNT 12'h04c
// global configuration codes
`define GPT_CFG_32 3'h0
`define GPT_CFG_RTC 3'h1
`define GPT_CFG_16 3'h4
// mode register fields
`define GPT_MODE_LSB 0
`define GPT_CMODE_BIT 2
`define GPT_MR_ONESHOT 2'h1
`define GPT_MR_PERIODIC 2'h2
`define GPT_MR_EDGECNT 2'h3
// control register: counter b fields sit GPT_CTL_B_SHIFT above counter a
`define GPT_CTL_EN 0
`define GPT_CTL_STALL 1
`define GPT_CTL_EVT 2
`define GPT_CTL_RTC_RUN_ENABLE 4
`define GPT_CTL_OTE 5
`define GPT_CTL_B_SHIFT 8
// event select codes
`define GPT_EVT_RISE 2'h0
`define GPT_EVT_FALL 2'h1
`define GPT_EVT_BOTH 2'h3
// status bits (raw, mask, masked, clear share them)
`define GPT_ST_ATO 0
`define GPT_ST_ACM 1
`define GPT_ST_RTC 3
`define GPT_ST_BTO 8
`define GPT_ST_BCM 9
// reset values
`define GPT_CNT_RST 16'hffff
`define GPT_PSC_RST 8'h00
`define GPT_RTC_FIRST 32'h0000_0001
// real-time input rate and tick rate, in hertz
`define GPT_RTC_IN_HZ 32768
`define GPT_RTC_OUT_HZ 1
`endif

// *** verilog/gpt_pkg.sv ***
// types shared by the timer design
package gpt_pkg;
  typedef logic [31:0] gpt_word_t;
  typedef logic [15:0] gpt_half_t;
  typedef logic [11:0] gpt_addr_t;
  // decoded global arrangement
  typedef enum logic [1:0] {GPT_ARR_32, GPT_ARR_RTC, GPT_ARR_16, GPT_ARR_OFF} gpt_arr_e;
endpackage : gpt_pkg

// *** verilog/gpt_timer.sv ***
// general purpose timer: two 16-bit counters, joined 32-bit and real-time modes, apb slave
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "gpt_params.svh"
module gpt_timer #(
  parameter int RTC_DIV = `GPT_RTC_IN_HZ / `GPT_RTC_OUT_HZ
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire gpt_pkg::gpt_addr_t paddr_i,
  input wire gpt_pkg::gpt_word_t pwdata_i,
  output gpt_pkg::gpt_word_t prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic ccp_a_i,
  input wire logic ccp_b_i,
  input wire logic dbg_halt_i,
  output logic adc_trig_o,
  output logic irq_o
);
  import gpt_pkg::*;

  localparam int DW = $clog2(RTC_DIV);

  // true for one-shot and periodic codes
  function automatic logic is_timer(input logic [2:0] mr);
    return (mr[1:0] == `GPT_MR_ONESHOT) || (mr[1:0] == `GPT_MR_PERIODIC);
  endfunction : is_timer

  // edge select decode
  function automatic logic edge_sel(input logic [1:0] evt, input logic rise, input logic fall);
    unique case (evt)
      `GPT_EVT_RISE: return rise;
      `GPT_EVT_FALL: return fall;
      `GPT_EVT_BOTH: return rise | fall;
      default: return 1'b0;
    endcase
  endfunction : edge_sel

  logic [2:0] cfg;
  logic [2:0] mode [2];
  logic [15:0] ctl;
  logic [15:0] imr;
  logic [15:0] ris;
  logic [31:0] match_a;
  gpt_half_t match_b;
  gpt_half_t ilr [2];
  logic [7:0] pr [2];
  gpt_half_t cnt [2];
  logic [7:0] psc [2];
  logic [1:0] en;
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic [DW-1:0] rtc_div;
  logic rtc_tick;

  //////////////////////////////////////////////////////////////////////////////
  // apb decode: zero wait states, writes land in the access cycle
  logic wr;
  logic hit;
  assign wr = psel_i & penable_i & pwrite_i;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~hit;

  // address is one of the mapped words
  always_comb begin
    unique case (paddr_i)
      `GPT_OFS_CFG, `GPT_OFS_AMODE, `GPT_OFS_BMODE, `GPT_OFS_CTL, `GPT_OFS_IMR, `GPT_OFS_RIS, `GPT_OFS_MIS,
      `GPT_OFS_ICR, `GPT_OFS_AILR, `GPT_OFS_BILR, `GPT_OFS_AMATCH, `GPT_OFS_BMATCH, `GPT_OFS_APR,
      `GPT_OFS_BPR, `GPT_OFS_ACNT, `GPT_OFS_BCNT: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  logic cfg_wr;
  logic ctl_wr;
  logic icr_wr;
  logic [1:0] ilr_wr;
  assign cfg_wr = wr & (paddr_i == `GPT_OFS_CFG);
  assign ctl_wr = wr & (paddr_i == `GPT_OFS_CTL);
  assign icr_wr = wr & (paddr_i == `GPT_OFS_ICR);
  assign ilr_wr[0] = wr & (paddr_i == `GPT_OFS_AILR);
  assign ilr_wr[1] = wr & (paddr_i == `GPT_OFS_BILR);

  // arrangement decode; other codes leave both counters idle
  gpt_arr_e arr;
  always_comb begin
    unique case (cfg)
      `GPT_CFG_32: arr = GPT_ARR_32;
      `GPT_CFG_RTC: arr = GPT_ARR_RTC;
      `GPT_CFG_16: arr = GPT_ARR_16;
      default: arr = GPT_ARR_OFF;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // software-only configuration registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cfg <= `GPT_CFG_32;
      mode[0] <= '0;
      mode[1] <= '0;
      ctl <= '0;
      imr <= '0;
      match_a <= '0;
      match_b <= '0;
      pr[0] <= `GPT_PSC_RST;
      pr[1] <= `GPT_PSC_RST;
    end else if (wr) begin
      unique case (paddr_i)
        `GPT_OFS_CFG: cfg <= pwdata_i[2:0];
        `GPT_OFS_AMODE: mode[0] <= pwdata_i[2:0];
        `GPT_OFS_BMODE: mode[1] <= pwdata_i[2:0];
        `GPT_OFS_CTL: ctl <= pwdata_i[15:0];
        `GPT_OFS_IMR: imr <= pwdata_i[15:0];
        `GPT_OFS_AMATCH: match_a <= pwdata_i;
        `GPT_OFS_BMATCH: match_b <= pwdata_i[15:0];
        `GPT_OFS_APR: pr[0] <= pwdata_i[7:0];
        `GPT_OFS_BPR: pr[1] <= pwdata_i[7:0];
        default: ;
      endcase
    end
  end

  // load registers; joined mode spreads a write over both halves
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ilr[0] <= `GPT_CNT_RST;
      ilr[1] <= `GPT_CNT_RST;
    end else if (ilr_wr[0] && arr != GPT_ARR_16) begin
      ilr[0] <= pwdata_i[15:0];
      ilr[1] <= pwdata_i[31:16];
    end else begin
      if (ilr_wr[0])
        ilr[0] <= pwdata_i[15:0];
      if (ilr_wr[1])
        ilr[1] <= pwdata_i[15:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // capture pins: two stages against metastability, third for edge compare
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {sync_a[1:0], ccp_a_i};
      sync_b <= {sync_b[1:0], ccp_b_i};
    end
  end

  logic [1:0] rise;
  logic [1:0] fall;
  // faster pins than clock/4 are not resolved
  assign rise = {sync_b[1] & ~sync_b[2], sync_a[1] & ~sync_a[2]};
  assign fall = {~sync_b[1] & sync_b[2], ~sync_a[1] & sync_a[2]};

  // divide the slow clock to a one hertz tick
  always_ff @(posedge clk_i) begin
    if (srst_i || arr != GPT_ARR_RTC) begin
      rtc_div <= '0;
      rtc_tick <= 1'b0;
    end else begin
      rtc_tick <= 1'b0;
      if (rise[0]) begin
        if (rtc_div == DW'(RTC_DIV - 1)) begin
          rtc_div <= '0;
          rtc_tick <= 1'b1;
        end else begin
          rtc_div <= rtc_div + 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // step and event terms
  logic [31:0] cnt32;
  logic [1:0] stall;
  logic [1:0] frz;
  logic [1:0] step;
  logic [1:0] to16;
  logic [1:0] ev;
  logic [1:0] cm;
  logic run32;
  logic to32;
  logic rtc_step;
  logic rtc_hit;
  assign cnt32 = {cnt[1], cnt[0]};
  assign stall = {ctl[`GPT_CTL_STALL + `GPT_CTL_B_SHIFT], ctl[`GPT_CTL_STALL]};
  assign frz = {2{dbg_halt_i}} & stall;
  // joined timer obeys the a mode only
  assign run32 = (arr == GPT_ARR_32) & en[0] & ~frz[0] & is_timer(mode[0]);
  assign to32 = run32 & (cnt32 == '0);
  // run enable overrides both stall bits
  assign rtc_step = (arr == GPT_ARR_RTC) & en[0] & rtc_tick & (~|frz | ctl[`GPT_CTL_RTC_RUN_ENABLE]);
  assign rtc_hit = rtc_step & (cnt32 == match_a);

  for (genvar i = 0; i < 2; i++) begin : g_evt
    logic [1:0] evt;
    logic [15:0] mt;
    assign evt = ctl[`GPT_CTL_EVT + i * `GPT_CTL_B_SHIFT +: 2];
    assign mt = (i == 0) ? match_a[15:0] : match_b;
    // step only when prescaler has run out
    assign step[i] = (arr == GPT_ARR_16) & en[i] & ~frz[i] & is_timer(mode[i]) & (psc[i] == '0);
    assign to16[i] = step[i] & (cnt[i] == '0);
    // edge count decode
    // edges seen during a stalled halt are dropped, so the count holds like the timers
    assign ev[i] = (arr == GPT_ARR_16) & en[i] & ~mode[i][`GPT_CMODE_BIT] & (mode[i][1:0] == `GPT_MR_EDGECNT)
      & ~frz[i] & edge_sel(evt, rise[i], fall[i]);
    assign cm[i] = ev[i] & (16'(cnt[i] - 1'b1) == mt);
  end

  //////////////////////////////////////////////////////////////////////////////
  // counters, prescalers and enables
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      // counters all ones, prescalers zero, idle
      cnt[0] <= `GPT_CNT_RST;
      cnt[1] <= `GPT_CNT_RST;
      psc[0] <= `GPT_PSC_RST;
      psc[1] <= `GPT_PSC_RST;
      en <= '0;
    end else begin
      unique case (arr)
        GPT_ARR_32: begin
          if (ilr_wr[0]) begin
            {cnt[1], cnt[0]} <= pwdata_i;
          end else if (to32) begin
            {cnt[1], cnt[0]} <= {ilr[1], ilr[0]};
            if (mode[0][1:0] == `GPT_MR_ONESHOT)
              en[0] <= 1'b0;
          end else if (run32) begin
            {cnt[1], cnt[0]} <= cnt32 - 1'b1;
          end
        end
        GPT_ARR_RTC: begin
          if (rtc_hit) begin
            {cnt[1], cnt[0]} <= '0;
          end else if (rtc_step) begin
            {cnt[1], cnt[0]} <= cnt32 + 1'b1;
          end
        end
        GPT_ARR_16: begin
          for (int i = 0; i < 2; i++) begin
            if (ilr_wr[i]) begin
              cnt[i] <= pwdata_i[15:0];
            end else if (to16[i]) begin
              cnt[i] <= ilr[i];
              psc[i] <= pr[i];
              if (mode[i][1:0] == `GPT_MR_ONESHOT)
                en[i] <= 1'b0;
            end else if (step[i]) begin
              cnt[i] <= cnt[i] - 1'b1;
              psc[i] <= pr[i];
            end else if (cm[i]) begin
              cnt[i] <= ilr[i];
              en[i] <= 1'b0;
            end else if (ev[i]) begin
              cnt[i] <= cnt[i] - 1'b1;
            end else if (en[i] && !frz[i] && is_timer(mode[i])) begin
              psc[i] <= psc[i] - 1'b1;
            end
          end
        end
        default: ;
      endcase
      // entering real-time mode starts at one; decided on the old arrangement
      if (cfg_wr && pwdata_i[2:0] == `GPT_CFG_RTC && cfg != `GPT_CFG_RTC)
        {cnt[1], cnt[0]} <= `GPT_RTC_FIRST;
      // a software write of the enables wins over a hardware clear
      if (ctl_wr) begin
        en[0] <= pwdata_i[`GPT_CTL_EN];
        en[1] <= pwdata_i[`GPT_CTL_EN + `GPT_CTL_B_SHIFT];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status: a new event wins over a clear in the same cycle
  logic [15:0] set;
  always_comb begin
    set = '0;
    set[`GPT_ST_ATO] = to32 | to16[0];
    set[`GPT_ST_BTO] = to16[1];
    set[`GPT_ST_ACM] = cm[0];
    set[`GPT_ST_BCM] = cm[1];
    set[`GPT_ST_RTC] = rtc_hit;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i)
      ris <= '0;
    else
      ris <= (ris & ~(icr_wr ? pwdata_i[15:0] : 16'h0000)) | set;
  end

  logic [15:0] mis;
  assign mis = ris & imr;
  assign irq_o = |mis;

  always_ff @(posedge clk_i) begin
    if (srst_i)
      adc_trig_o <= 1'b0;
    else
      adc_trig_o <= (set[`GPT_ST_ATO] & ctl[`GPT_CTL_OTE]) | (to16[1] & ctl[`GPT_CTL_OTE + `GPT_CTL_B_SHIFT]);
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data captured in the setup cycle, stable through the access
  logic joined;
  assign joined = (arr == GPT_ARR_32) | (arr == GPT_ARR_RTC);
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prdata_o <= '0;
    end else if (psel_i && !penable_i) begin
      unique case (paddr_i)
        `GPT_OFS_CFG: prdata_o <= {29'h0, cfg};
        `GPT_OFS_AMODE: prdata_o <= {29'h0, mode[0]};
        `GPT_OFS_BMODE: prdata_o <= {29'h0, mode[1]};
        `GPT_OFS_CTL: prdata_o <= {16'h0, ctl[15:9], en[1], ctl[7:1], en[0]};
        `GPT_OFS_IMR: prdata_o <= {16'h0, imr};
        `GPT_OFS_RIS: prdata_o <= {16'h0, ris};
        `GPT_OFS_MIS: prdata_o <= {16'h0, mis};
        `GPT_OFS_AILR: prdata_o <= joined ? {ilr[1], ilr[0]} : {16'h0, ilr[0]};
        `GPT_OFS_BILR: prdata_o <= {16'h0, ilr[1]};
        `GPT_OFS_AMATCH: prdata_o <= match_a;
        `GPT_OFS_BMATCH: prdata_o <= {16'h0, match_b};
        `GPT_OFS_APR: prdata_o <= {24'h0, pr[0]};
        `GPT_OFS_BPR: prdata_o <= {24'h0, pr[1]};
        `GPT_OFS_ACNT: prdata_o <= joined ? cnt32 : {16'h0, cnt[0]};
        `GPT_OFS_BCNT: prdata_o <= {16'h0, cnt[1]};
        default: prdata_o <= '0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_zero32;
    run32 && cnt32 == '0 && !ilr_wr[0];
  endsequence
  sequence s_reload32;
    ##1 cnt32 == $past({ilr[1], ilr[0]});
  endsequence

  a_zero_reload: assert property (s_zero32 |-> s_reload32) else $error("joined reload wrong");
  a_oneshot_stop: assert property ((s_zero32 and (mode[0][1:0] == `GPT_MR_ONESHOT && !ctl_wr)) |=> !en[0])
    else $error("one-shot left enabled");
  a_timeout_raw: assert property (to32 |=> ris[`GPT_ST_ATO]) else $error("time-out flag missing");
  a_trig_gate: assert property (adc_trig_o |-> $past(ctl[`GPT_CTL_OTE] | ctl[`GPT_CTL_OTE + `GPT_CTL_B_SHIFT]))
    else $error("trigger without enable");
  a_load_taken: assert property (ilr_wr[0] && arr == GPT_ARR_32 |=> cnt32 == $past(pwdata_i))
    else $error("load not taken");
  a_stall_hold: assert property (arr != GPT_ARR_RTC && frz[0] && !ilr_wr[0] && !cfg_wr |=> cnt[0] == $past(cnt[0]))
    else $error("stalled counter moved");
  a_rtc_wrap: assert property (rtc_hit |=> cnt32 == '0 && ris[`GPT_ST_RTC]) else $error("rtc wrap wrong");
  a_psc_span: assert property (step[0] && cnt[0] != '0 && pr[0] == 8'h01 && !frz[0] && !ilr_wr[0] && !ctl_wr
    |=> !step[0] ##1 (step[0] || !en[0] || frz[0])) else $error("prescale span wrong");
  a_match_stop: assert property (cm[0] && !ctl_wr |=> !en[0] && cnt[0] == $past(ilr[0]))
    else $error("edge match no stop");
  a_stall_hold_b: assert property (arr == GPT_ARR_16 && frz[1] && !ilr_wr[1] && !cfg_wr
    |=> cnt[1] == $past(cnt[1])) else $error("stalled counter b moved");
  a_psc_reload_b: assert property (step[1] && !ilr_wr[1] |=> psc[1] == $past(pr[1]))
    else $error("prescale b not reloaded");
  a_match_stop_b: assert property (cm[1] && !ctl_wr && !ilr_wr[1] && !cfg_wr
    |=> !en[1] && cnt[1] == $past(ilr[1])) else $error("edge match b no stop");
endmodule : gpt_timer

// *** test/gpt_pin_model.sv ***
// far-side model of the capture pins: slow input clock on pin a, edge bursts on pin b
`timescale 1ns/1ps
module gpt_pin_model (
  input wire logic clk_i,
  input wire logic osc_en_i,
  output logic ccp_a_o,
  output logic ccp_b_o
);
  logic [1:0] ph;
  initial begin
    ph = 2'h0;
    ccp_a_o = 1'b0;
    ccp_b_o = 1'b0;
  end
  // slow input clock
  // each level held two clocks, the fastest rate the pin accepts; stands still when off
  always @(posedge clk_i) begin
    if (osc_en_i) begin
      ph <= ph + 2'h1;
      ccp_a_o <= ph[1];
    end
  end
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_i);
      ccp_b_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      ccp_b_o <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
  endtask : pulses
endmodule : gpt_pin_model

// *** test/tb_gpt_timer.sv ***
// self-checking bench of the timer through its apb port and capture pins
`timescale 1ns/1ps
`include "gpt_params.svh"
module tb_gpt_timer;
  import gpt_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  gpt_addr_t paddr_i = 12'h000;
  gpt_word_t pwdata_i = 32'h0;
  gpt_word_t prdata_o;
  logic pready_o, pslverr_o, ccp_a_i, ccp_b_i, adc_trig_o, irq_o;
  logic dbg_halt_i = 1'b0;
  logic osc_en = 1'b0;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int trig_n = 0;
  int trig_base = 0;
  int t_last = 0;
  int t_prev = 0;
  int i;
  logic err;
  gpt_word_t q;
  int ev_code[3] = '{0, 1, 3};
  gpt_word_t ev_exp[3] = '{32'h8, 32'h8, 32'h6};

  always #5 clk_i = ~clk_i;

  // small divider so a real-time tick is four input periods
  gpt_timer #(.RTC_DIV(4)) i_gpt_timer (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .ccp_a_i(ccp_a_i),
    .ccp_b_i(ccp_b_i), .dbg_halt_i(dbg_halt_i), .adc_trig_o(adc_trig_o), .irq_o(irq_o));
  gpt_pin_model i_gpt_pin_model (.clk_i(clk_i), .osc_en_i(osc_en), .ccp_a_o(ccp_a_i), .ccp_b_o(ccp_b_i));

  // trigger pulses and their spacing in cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (adc_trig_o === 1'b1) begin
      trig_n <= trig_n + 1;
      t_prev <= t_last;
      t_last <= cyc;
    end
  end

  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string name, input gpt_word_t seen, input gpt_word_t exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // apb transfer: setup, then access held until pready is seen high
  task automatic apb(input logic w, input gpt_addr_t a, input gpt_word_t d, output gpt_word_t r,
                     output logic e);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic wr(input gpt_addr_t a, input gpt_word_t d);
    gpt_word_t r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdchk(input gpt_addr_t a, input gpt_word_t exp, input string name);
    gpt_word_t r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(name, r, exp);
  endtask : rdchk

  // bounded wait: gives up after 500 cycles without an interrupt and counts a failure itself
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq_o !== 1'b1 && n < 500) begin
      @(posedge clk_i);
      n++;
    end
    if (irq_o !== 1'b1) begin
      num_errors++;
      $display("FAIL irq_o expected 1 seen %b", irq_o);
    end
  endtask : wait_irq

  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    $display("FAIL watchdog expired");
    end_of_test();
  end

  initial begin
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    // reset state and an unmapped word
    rdchk(`GPT_OFS_ACNT, 32'hffff_ffff, "acnt_reset");
    rdchk(`GPT_OFS_BILR, 32'h0000_ffff, "bilr_reset");
    rdchk(`GPT_OFS_APR, 32'h0, "apr_reset");
    rdchk(`GPT_OFS_CTL, 32'h0, "ctl_reset");
    apb(1'b0, 12'h040, 32'h0, q, err);
    chk("unmapped_err", {31'h0, err}, 32'h1);
    chk("unmapped_data", q, 32'h0);
    $display("test reset done");
    // joined one-shot, b mode set to periodic must not matter
    wr(`GPT_OFS_AMODE, 32'h1);
    wr(`GPT_OFS_BMODE, 32'h2);
    wr(`GPT_OFS_AILR, 32'h0003_0005);
    rdchk(`GPT_OFS_BILR, 32'h3, "bilr_split");
    rdchk(`GPT_OFS_ACNT, 32'h0003_0005, "acnt_join");
    wr(`GPT_OFS_AILR, 32'h6);
    rdchk(`GPT_OFS_ACNT, 32'h6, "acnt_reload");
    wr(`GPT_OFS_IMR, 32'h1);
    trig_base = trig_n;
    wr(`GPT_OFS_CTL, 32'h21);
    wait_irq();
    rdchk(`GPT_OFS_RIS, 32'h1, "ris_ato");
    rdchk(`GPT_OFS_MIS, 32'h1, "mis_ato");
    rdchk(`GPT_OFS_CTL, 32'h20, "ctl_oneshot");
    rdchk(`GPT_OFS_ACNT, 32'h6, "acnt_stop");
    chk("trig_once", trig_n - trig_base, 32'h1);
    wr(`GPT_OFS_ICR, 32'h1);
    rdchk(`GPT_OFS_RIS, 32'h0, "ris_clear");
    chk("irq_clear", {31'h0, irq_o}, 32'h0);
    $display("test joined one-shot done");
    // split periodic b with prescaler, time-out masked off
    wr(`GPT_OFS_CFG, 32'h4);
    wr(`GPT_OFS_IMR, 32'h0);
    wr(`GPT_OFS_BMODE, 32'h2);
    wr(`GPT_OFS_BPR, 32'h3);
    wr(`GPT_OFS_BILR, 32'h4);
    trig_base = trig_n;
    wr(`GPT_OFS_CTL, 32'h2100);
    i = 0;
    while (trig_n - trig_base < 2 && i < 200) begin
      @(posedge clk_i);
      i++;
    end
    chk("trig_gap", t_last - t_prev, 32'd20);
    rdchk(`GPT_OFS_RIS, 32'h100, "ris_bto");
    rdchk(`GPT_OFS_MIS, 32'h0, "mis_masked");
    chk("irq_masked", {31'h0, irq_o}, 32'h0);
    rdchk(`GPT_OFS_CTL, 32'h2100, "ctl_periodic");
    wr(`GPT_OFS_CTL, 32'h2300);
    dbg_halt_i <= 1'b1;
    apb(1'b0, `GPT_OFS_BCNT, 32'h0, q, err);
    repeat (10) @(posedge clk_i);
    rdchk(`GPT_OFS_BCNT, q, "bcnt_stall");
    dbg_halt_i <= 1'b0;
    wr(`GPT_OFS_CTL, 32'h0);
    wr(`GPT_OFS_ICR, 32'h100);
    $display("test split periodic done");
    // edge counting for each event code, match never reached
    wr(`GPT_OFS_BMODE, 32'h3);
    for (i = 0; i < 3; i++) begin
      wr(`GPT_OFS_BILR, 32'ha);
      wr(`GPT_OFS_CTL, (ev_code[i] << 10) | 32'h100);
      i_gpt_pin_model.pulses(2);
      repeat (6) @(posedge clk_i);
      rdchk(`GPT_OFS_BCNT, ev_exp[i], "bcnt_edges");
      wr(`GPT_OFS_CTL, 32'h0);
    end
    // six edges offered, four counted to the match, rest ignored
    wr(`GPT_OFS_IMR, 32'h200);
    wr(`GPT_OFS_BMATCH, 32'h6);
    wr(`GPT_OFS_BILR, 32'ha);
    wr(`GPT_OFS_CTL, 32'hd00);
    i_gpt_pin_model.pulses(3);
    repeat (6) @(posedge clk_i);
    rdchk(`GPT_OFS_RIS, 32'h200, "ris_match");
    rdchk(`GPT_OFS_MIS, 32'h200, "mis_match");
    rdchk(`GPT_OFS_CTL, 32'hc00, "ctl_match");
    rdchk(`GPT_OFS_BCNT, 32'ha, "bcnt_match");
    wr(`GPT_OFS_ICR, 32'h200);
    $display("test edge count done");
    // real-time clock, halted with the a stall bit but run enable set
    wr(`GPT_OFS_CFG, 32'h1);
    rdchk(`GPT_OFS_ACNT, 32'h1, "rtc_first");
    wr(`GPT_OFS_AMATCH, 32'h3);
    wr(`GPT_OFS_IMR, 32'h8);
    dbg_halt_i <= 1'b1;
    wr(`GPT_OFS_CTL, 32'h113);
    osc_en <= 1'b1;
    wait_irq();
    rdchk(`GPT_OFS_ACNT, 32'h0, "rtc_wrap");
    rdchk(`GPT_OFS_RIS, 32'h8, "ris_rtc");
    wr(`GPT_OFS_ICR, 32'h8);
    rdchk(`GPT_OFS_MIS, 32'h0, "mis_rtc_clear");
    osc_en <= 1'b0;
    dbg_halt_i <= 1'b0;
    $display("test real-time done");
    end_of_test();
  end
endmodule : tb_gpt_timer
